// File: hdl/move_instruction_decoder.sv
// Decoder and state sequencer for the data transfer instructions.
// Assumes a fetch path offering both instruction words together and a
// datapath that returns the transferred value as a one-cycle strobe.
`timescale 1ns/1ns

// What this block does
// - Opcode class chosen from first byte
// - Shared first bytes split by bit seven
// - Push and pop decode as stack moves
// - Moves set N, Z; clear V
// - Moves keep I, H, C flags
// - Immediate fields are 3, 8, 16 bits
// - Absolute fields 8 or 16; displacement 16
// - Byte move states: 2, 4 or 6
// - Displacement byte moves: 4 bytes, 6 states
// - Postincrement byte load reads, then adds one
// - Postincrement word load reads, then adds two
// - Predecrement byte store subtracts first, then writes
module move_instruction_decoder (
    // Clock and reset
    input wire logic mclk_in,
    input wire logic sys_rst_in,
    // Instruction fetch
    input wire logic instr_valid_in,
    input wire logic [15:0] instr_word0_in,
    input wire logic [15:0] instr_word1_in,
    output logic instr_ready_out,
    // Decoded instruction and sequencing
    output move_dec_pkg::decode_s decode_out,
    output logic busy_out,
    output logic done_out,
    // Transfer value and condition flags
    input wire logic xfer_valid_in,
    input wire logic [15:0] xfer_data_in,
    input wire logic [7:0] flags_in,
    output logic [7:0] flags_out,
    output logic flags_we_out
);
    import move_dec_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // Fields shared by the first-byte pairs split by bit seven
    function automatic decode_s paired_form(input decode_s base, input logic [7:0] opc, input logic sel);
        decode_s d;
        d = base;
        d.op_class = CLASS_MOVE;
        d.is_word = opc[0];
        d.is_store = sel;
        return d;
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Decode of one instruction
    function automatic decode_s decode_instr(input logic [15:0] w0, input logic [15:0] w1);
        decode_s d;
        logic [7:0] opc;
        logic sel;
        d = '0;
        opc = w0[OPC_HI:OPC_LO];
        sel = w0[PAIR_SEL_BIT];
        d.op_class = CLASS_OTHER;
        d.mode = MODE_REG;
        d.length = LEN_SHORT;
        d.states = STATES_FAST;
        d.data_reg = w0[3:0];
        d.ptr_reg = {1'b0, w0[6:4]};
        if (opc[7:4] == OPC_BYTE_IMM_HI) begin
            d.op_class = CLASS_MOVE;
            d.mode = MODE_IMM;
            d.data_reg = opc[3:0];
            d.imm = {8'h00, w0[7:0]};
            d.imm_width = FIELD_8;
            d.states = STATES_FAST;
        end else if (opc == OPC_BYTE_REG || opc == OPC_WORD_REG) begin
            d.op_class = CLASS_MOVE;
            d.is_word = opc[0];
            d.mode = MODE_REG;
            d.ptr_reg = w0[7:4];
            d.states = STATES_FAST;
        end else if (opc[7:4] == OPC_ABS8_LOAD_HI || opc[7:4] == OPC_ABS8_STORE_HI) begin
            d.op_class = CLASS_MOVE;
            d.is_store = (opc[7:4] == OPC_ABS8_STORE_HI);
            d.mode = MODE_ABS;
            d.data_reg = opc[3:0];
            d.ea_field = {8'h00, w0[7:0]};
            d.ea_width = FIELD_8;
            d.states = STATES_MID;
        end else if (opc == OPC_WORD_IMM && w0[7:4] == 4'h0) begin
            d.op_class = CLASS_MOVE;
            d.is_word = 1'b1;
            d.mode = MODE_IMM;
            d.imm = w1;
            d.imm_width = FIELD_16;
            d.length = LEN_LONG;
            d.states = STATES_MID;
        end else if (opc[7:1] == OPC_INDIRECT) begin
            d = paired_form(d, opc, sel);
            d.mode = MODE_IND;
            d.states = STATES_MID;
        end else if (opc[7:1] == OPC_ABS16) begin
            d = paired_form(d, opc, sel);
            d.mode = MODE_ABS;
            d.ea_field = w1;
            d.ea_width = FIELD_16;
            d.length = LEN_LONG;
            d.states = STATES_SLOW;
        end else if (opc[7:1] == OPC_DISP16) begin
            d = paired_form(d, opc, sel);
            d.mode = MODE_DISP;
            d.ea_field = w1;
            d.ea_width = FIELD_16;
            d.length = LEN_LONG;
            d.states = STATES_SLOW;
        end else if (opc[7:1] == OPC_AUTO_STEP) begin
            d = paired_form(d, opc, sel);
            d.mode = sel ? MODE_PREDEC : MODE_POSTINC;
            d.step = opc[0] ? STEP_WORD : STEP_BYTE;
            d.step_first = sel;
            d.is_stack = opc[0] && (w0[6:4] == STACK_PTR_REG);
            d.states = STATES_SLOW;
        end else if (opc[7:3] == OPC_BIT_IMM3) begin
            d.imm = {13'h0000, w0[6:4]};
            d.imm_width = FIELD_3;
        end
        return d;
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Sequencer state
    seq_state_e state_q, state_d;
    decode_s dec_q, dec_d;
    logic [2:0] count_q, count_d;
    logic ready_q, ready_d;
    logic done_q, done_d;
    logic busy_q, busy_d;
    logic accept;
    logic flag_update;

    // Fetch waits while ready is low
    assign accept = ready_q && instr_valid_in;

    always_comb begin
        state_d = state_q;
        dec_d = dec_q;
        count_d = count_q;
        ready_d = ready_q;
        done_d = 1'b0;
        busy_d = busy_q;
        case (state_q)
            SEQ_IDLE: begin
                if (accept) begin
                    dec_d = decode_instr(instr_word0_in, instr_word1_in);
                    count_d = dec_d.states;
                    ready_d = 1'b0;
                    busy_d = 1'b1;
                    state_d = SEQ_EXEC;
                end
            end
            SEQ_EXEC: begin
                count_d = count_q - 3'h1;
                if (count_q == 3'h1) begin
                    done_d = 1'b1;
                    state_d = SEQ_DONE;
                end
            end
            SEQ_DONE: begin
                ready_d = 1'b1;
                busy_d = 1'b0;
                state_d = SEQ_IDLE;
            end
            default: begin
                ready_d = 1'b1;
                busy_d = 1'b0;
                state_d = SEQ_IDLE;
            end
        endcase
    end

    always_ff @(posedge mclk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            state_q <= SEQ_IDLE;
            dec_q <= '0;
            count_q <= 3'h0;
            ready_q <= 1'b1;
            done_q <= 1'b0;
            busy_q <= 1'b0;
        end else begin
            state_q <= state_d;
            dec_q <= dec_d;
            count_q <= count_d;
            ready_q <= ready_d;
            done_q <= done_d;
            busy_q <= busy_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Flag update from the transferred value
    assign flag_update = xfer_valid_in
        && (state_q == SEQ_EXEC)
        && (dec_q.op_class == CLASS_MOVE);

    move_flag_unit u_flags (
        .mclk_in(mclk_in),
        .sys_rst_in(sys_rst_in),
        .update_in(flag_update),
        .is_word_in(dec_q.is_word),
        .value_in(xfer_data_in),
        .flags_in(flags_in),
        .flags_out(flags_out),
        .flags_we_out(flags_we_out)
    );

    ////////////////////////////////////////////////////////////////////////
    // Outputs
    assign instr_ready_out = ready_q;
    assign decode_out = dec_q;
    assign busy_out = busy_q;
    assign done_out = done_q;
endmodule

// File: hdl/move_dec_pkg.sv
// Shared constants and carriers for the move instruction decoder.
// Assumes one system clock and a fetch path that offers whole instructions.
package move_dec_pkg;

    ////////////////////////////////////////////////////////////////////////
    // First byte values and masks of the move forms
    localparam logic [7:0] OPC_BYTE_REG = 8'h0C;
    localparam logic [7:0] OPC_WORD_REG = 8'h0D;
    localparam logic [3:0] OPC_ABS8_LOAD_HI = 4'h2;
    localparam logic [3:0] OPC_ABS8_STORE_HI = 4'h3;
    localparam logic [3:0] OPC_BYTE_IMM_HI = 4'hF;
    localparam logic [6:0] OPC_INDIRECT = 7'h34;
    localparam logic [6:0] OPC_ABS16 = 7'h35;
    localparam logic [6:0] OPC_AUTO_STEP = 7'h36;
    localparam logic [6:0] OPC_DISP16 = 7'h37;
    localparam logic [7:0] OPC_WORD_IMM = 8'h79;
    localparam logic [4:0] OPC_BIT_IMM3 = 5'h0E;
    localparam logic [2:0] STACK_PTR_REG = 3'h7;

    ////////////////////////////////////////////////////////////////////////
    // Field positions
    localparam int OPC_HI = 15;
    localparam int OPC_LO = 8;
    localparam int PAIR_SEL_BIT = 7;

    ////////////////////////////////////////////////////////////////////////
    // Condition flag positions and reset value
    localparam int FLAG_I = 7;
    localparam int FLAG_H = 5;
    localparam int FLAG_N = 3;
    localparam int FLAG_Z = 2;
    localparam int FLAG_V = 1;
    localparam int FLAG_C = 0;
    localparam logic [7:0] FLAGS_RESET = 8'h80;

    ////////////////////////////////////////////////////////////////////////
    // Instruction lengths in bytes and execution state counts
    localparam logic [2:0] LEN_SHORT = 3'h2;
    localparam logic [2:0] LEN_LONG = 3'h4;
    localparam logic [2:0] STATES_FAST = 3'h2;
    localparam logic [2:0] STATES_MID = 3'h4;
    localparam logic [2:0] STATES_SLOW = 3'h6;
    localparam logic [1:0] STEP_BYTE = 2'h1;
    localparam logic [1:0] STEP_WORD = 2'h2;

    ////////////////////////////////////////////////////////////////////////
    // Types
    typedef enum logic [1:0] {
        CLASS_NONE = 2'h0,
        CLASS_MOVE = 2'h1,
        CLASS_OTHER = 2'h2
    } op_class_e;

    typedef enum logic [2:0] {
        MODE_IMM = 3'h0,
        MODE_REG = 3'h1,
        MODE_IND = 3'h2,
        MODE_DISP = 3'h3,
        MODE_POSTINC = 3'h4,
        MODE_PREDEC = 3'h5,
        MODE_ABS = 3'h6
    } addr_mode_e;

    typedef enum logic [1:0] {
        FIELD_NONE = 2'h0,
        FIELD_3 = 2'h1,
        FIELD_8 = 2'h2,
        FIELD_16 = 2'h3
    } field_width_e;

    typedef enum logic [1:0] {
        SEQ_IDLE = 2'b00,
        SEQ_EXEC = 2'b01,
        SEQ_DONE = 2'b11
    } seq_state_e;

    typedef struct packed {
        op_class_e op_class;
        logic is_word;
        logic is_store;
        logic is_stack;
        addr_mode_e mode;
        logic [3:0] data_reg;
        logic [3:0] ptr_reg;
        logic [15:0] imm;
        field_width_e imm_width;
        logic [15:0] ea_field;
        field_width_e ea_width;
        logic [1:0] step;
        logic step_first;
        logic [2:0] length;
        logic [2:0] states;
    } decode_s;

endpackage

// File: hdl/move_flag_unit.sv
// Condition flag update for data transfers.
// Assumes the transferred value is offered as a one-cycle strobe.
`timescale 1ns/1ns
module move_flag_unit (
    // Clock and reset
    input wire logic mclk_in,
    input wire logic sys_rst_in,
    // Transfer value
    input wire logic update_in,
    input wire logic is_word_in,
    input wire logic [15:0] value_in,
    input wire logic [7:0] flags_in,
    // Updated flags
    output logic [7:0] flags_out,
    output logic flags_we_out
);
    import move_dec_pkg::*;

    logic [7:0] flags_q, flags_d;
    logic we_q, we_d;

    ////////////////////////////////////////////////////////////////////////
    // Next flags
    always_comb begin
        flags_d = flags_q;
        we_d = 1'b0;
        if (update_in) begin
            flags_d = flags_in;
            flags_d[FLAG_N] = is_word_in ? value_in[15] : value_in[7];
            flags_d[FLAG_Z] = is_word_in ? (value_in == 16'h0000) : (value_in[7:0] == 8'h00);
            flags_d[FLAG_V] = 1'b0;
            we_d = 1'b1;
        end
    end

    always_ff @(posedge mclk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            flags_q <= FLAGS_RESET;
            we_q <= 1'b0;
        end else begin
            flags_q <= flags_d;
            we_q <= we_d;
        end
    end

    assign flags_out = flags_q;
    assign flags_we_out = we_q;
endmodule

// File: testbench/move_dec_monitor.sv
// Checker for the move instruction decoder ports.
// Assumes one clock domain and a bind from the bench top.
`timescale 1ns/1ns
module move_dec_monitor (
    // Clock and fetch
    input wire logic mclk_in,
    input wire logic sys_rst_in,
    input wire logic instr_valid_in,
    input wire logic [15:0] instr_word0_in,
    input wire logic instr_ready_out,
    // Decode and sequencing
    input wire move_dec_pkg::decode_s decode_out,
    input wire logic busy_out,
    input wire logic done_out,
    // Flags
    input wire logic xfer_valid_in,
    input wire logic [15:0] xfer_data_in,
    input wire logic [7:0] flags_in,
    input wire logic [7:0] flags_out,
    input wire logic flags_we_out
);
    import move_dec_pkg::*;
    logic [3:0] cnt_q;
    logic [3:0] cnt_d;
    logic acc;
    assign acc = instr_valid_in && instr_ready_out;
    always_comb cnt_d = acc ? 4'h1 : (busy_out ? cnt_q + 4'h1 : cnt_q);
    always_ff @(posedge mclk_in or posedge sys_rst_in) cnt_q <= sys_rst_in ? 4'h0 : cnt_d;
    default clocking @(posedge mclk_in); endclocking
    default disable iff (sys_rst_in);
    ////////////////////////////////////////////////////////////////////////
    AST_ACCEPT: assert property (acc |=> busy_out && !instr_ready_out && !done_out)
        else $error("accept did not start execution");
    AST_CLASS: assert property (acc && instr_word0_in[15:8] == 8'h0C |=>
        decode_out.op_class == CLASS_MOVE && decode_out.states == STATES_FAST) else $error("register move decode");
    AST_PAIR: assert property (acc && instr_word0_in[15:10] == 6'h1B |=>
        decode_out.is_store == $past(instr_word0_in[7])) else $error("bit 7 pair split");
    AST_STEP: assert property (acc && instr_word0_in[15:9] == 7'h36 |=>
        decode_out.step_first == $past(instr_word0_in[7]) &&
        decode_out.step == ($past(instr_word0_in[8]) ? STEP_WORD : STEP_BYTE)) else $error("auto step");
    AST_STACK: assert property (acc && instr_word0_in[15:8] == 8'h6D && instr_word0_in[6:4] == 3'h7 |=>
        decode_out.is_stack) else $error("stack form not flagged");
    AST_DISP: assert property (acc && instr_word0_in[15:9] == 7'h37 |=>
        decode_out.length == LEN_LONG && decode_out.states == STATES_SLOW) else $error("displacement form");
    AST_COUNT: assert property (done_out |-> cnt_q == {1'b0, decode_out.states} + 4'h1)
        else $error("state count");
    AST_DONE: assert property (done_out |=> !done_out && !busy_out && instr_ready_out)
        else $error("end of execution");
    AST_FLAGNV: assert property (xfer_valid_in && busy_out && !done_out && decode_out.op_class == CLASS_MOVE
        |=> flags_we_out && !flags_out[FLAG_V] && flags_out[FLAG_N] ==
        $past(decode_out.is_word ? xfer_data_in[15] : xfer_data_in[7])) else $error("N or V flag");
    AST_FLAGKEEP: assert property (flags_we_out |-> flags_out[FLAG_I] == $past(flags_in[FLAG_I]) &&
        flags_out[FLAG_H] == $past(flags_in[FLAG_H]) && flags_out[FLAG_C] == $past(flags_in[FLAG_C]))
        else $error("kept flag changed");
    COV_DONE: cover property (done_out);
    COV_FLAGS: cover property (flags_we_out);
    COV_STACK: cover property (done_out && decode_out.is_stack);
endmodule

// File: testbench/move_xfer_model.sv
// Datapath model: returns one transferred value per instruction.
// Assumes busy from the decoder marks the execution span.
`timescale 1ns/1ns
module move_xfer_model (
    // Clock and reset
    input wire logic mclk_in,
    input wire logic sys_rst_in,
    // Decoder side
    input wire logic busy_in,
    input wire logic [15:0] value_in,
    output logic xfer_valid_out,
    output logic [15:0] xfer_data_out
);
    logic busy_q;
    logic fire;
    assign fire = busy_in && !busy_q;
    always_ff @(posedge mclk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            busy_q <= 1'b0;
            xfer_valid_out <= 1'b0;
            xfer_data_out <= 16'h0000;
        end else begin
            busy_q <= busy_in;
            xfer_valid_out <= fire;
            // Data only means something with the strobe
            xfer_data_out <= fire ? value_in : ~xfer_data_out;
        end
    end
endmodule

// File: testbench/move_instruction_decoder_tb.sv
// Bench for the move instruction decoder.
// Assumes the datapath model in move_xfer_model.
`timescale 1ns/1ns
module move_instruction_decoder_tb;
    import move_dec_pkg::*;
    logic mclk_in = 1'b0;
    logic sys_rst_in = 1'b1;
    logic vld = 1'b0;
    logic rdy, busy, done, xv, fwe;
    logic [15:0] w0 = 16'h0000;
    logic [15:0] w1 = 16'h0000;
    logic [15:0] val = 16'h0000;
    logic [15:0] xd;
    logic [7:0] fin = 8'h00;
    logic [7:0] fout;
    decode_s dec;
    int err_total = 0;
    int comparisons = 0;
    always #5 mclk_in = ~mclk_in;
    move_instruction_decoder DUT (.mclk_in(mclk_in), .sys_rst_in(sys_rst_in), .instr_valid_in(vld),
        .instr_word0_in(w0), .instr_word1_in(w1), .instr_ready_out(rdy), .decode_out(dec), .busy_out(busy),
        .done_out(done), .xfer_valid_in(xv), .xfer_data_in(xd), .flags_in(fin), .flags_out(fout),
        .flags_we_out(fwe));
    move_xfer_model PARTNER (.mclk_in(mclk_in), .sys_rst_in(sys_rst_in), .busy_in(busy), .value_in(val),
        .xfer_valid_out(xv), .xfer_data_out(xd));
    ////////////////////////////////////////////////////////////////////////
    task chk(input string nm, input logic [15:0] got, input logic [15:0] exp);
        comparisons++;
        if (got !== exp) begin
            err_total++;
            $display("[ERR] %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task summarize;
        if (err_total == 0 && comparisons > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    // One instruction; a refused request is held up during execution
    task run(input logic [15:0] a, b, d, input logic [7:0] f, input op_class_e cls, input addr_mode_e m,
             input logic [2:0] ln, st, input logic [7:0] ef);
        int n;
        int k;
        int nw;
        logic [7:0] fl;
        k = 0;
        nw = 0;
        fl = 8'hXX;
        w0 = a;
        w1 = b;
        val = d;
        fin = f;
        vld = 1'b1;
        @(negedge mclk_in);
        w0 = 16'h0000;
        chk("busy", {busy, rdy}, 16'h0002);
        chk("class", dec.op_class, cls);
        if (cls == CLASS_MOVE) begin
            chk("mode", dec.mode, m);
            chk("length", dec.length, ln);
        end
        for (n = 1; n < 20 && !rdy; n++) begin
            if (done === 1'b1) k = n;
            if (fwe === 1'b1) begin
                fl = fout;
                nw++;
            end
            @(negedge mclk_in);
        end
        vld = 1'b0;
        @(negedge mclk_in);
        chk("states", 16'(k), 16'(st) + 16'h1);
        chk("flag_we", 16'(nw), {15'h0000, cls == CLASS_MOVE});
        if (cls == CLASS_MOVE) chk("flags", fl, ef);
        chk("held", dec.op_class, cls);
    endtask
    task t_byte_forms;
        run(16'hF3A5, 16'h0000, 16'h00A5, 8'hFF, CLASS_MOVE, MODE_IMM, 3'h2, 3'h2, 8'hF9);
        chk("imm", dec.imm, 16'h00A5);
        chk("dst", dec.data_reg, 16'h0003);
        chk("imm_w", dec.imm_width, FIELD_8);
        run(16'h0C12, 16'h0000, 16'h0000, 8'h00, CLASS_MOVE, MODE_REG, 3'h2, 3'h2, 8'h04);
        chk("regs", {dec.ptr_reg, dec.data_reg}, 16'h0012);
        run(16'h6812, 16'h0000, 16'h0000, 8'hFF, CLASS_MOVE, MODE_IND, 3'h2, 3'h4, 8'hF5);
        run(16'h2345, 16'h0000, 16'h0080, 8'h22, CLASS_MOVE, MODE_ABS, 3'h2, 3'h4, 8'h28);
        chk("ea8", dec.ea_field, 16'h0045);
        chk("ea_w8", dec.ea_width, FIELD_8);
        run(16'h6A92, 16'h1234, 16'h007F, 8'h00, CLASS_MOVE, MODE_ABS, 3'h4, 3'h6, 8'h00);
        chk("ea16", dec.ea_field, 16'h1234);
        chk("store", dec.is_store, 16'h0001);
        run(16'h6E12, 16'hFFFE, 16'h0001, 8'h00, CLASS_MOVE, MODE_DISP, 3'h4, 3'h6, 8'h00);
        chk("disp_w", dec.ea_width, FIELD_16);
        run(16'h6E92, 16'h0010, 16'h0001, 8'h00, CLASS_MOVE, MODE_DISP, 3'h4, 3'h6, 8'h00);
        chk("store", dec.is_store, 16'h0001);
    endtask
    task t_auto_step;
        run(16'h6C12, 16'h0000, 16'h0000, 8'h00, CLASS_MOVE, MODE_POSTINC, 3'h2, 3'h6, 8'h04);
        chk("step", {dec.step, dec.step_first, dec.is_store}, {STEP_BYTE, 2'b00});
        run(16'h6C92, 16'h0000, 16'h0000, 8'h00, CLASS_MOVE, MODE_PREDEC, 3'h2, 3'h6, 8'h04);
        chk("step", {dec.step, dec.step_first, dec.is_store}, {STEP_BYTE, 2'b11});
        run(16'h6D13, 16'h0000, 16'h0080, 8'h00, CLASS_MOVE, MODE_POSTINC, 3'h2, 3'h6, 8'h00);
        chk("step", {dec.step, dec.step_first, dec.is_word}, {STEP_WORD, 2'b01});
        run(16'h6DF4, 16'h0000, 16'h8000, 8'h00, CLASS_MOVE, MODE_PREDEC, 3'h2, 3'h6, 8'h08);
        chk("push", {dec.is_stack, dec.is_store}, 16'h0003);
        chk("sp", {dec.ptr_reg, dec.data_reg}, 16'h0074);
        run(16'h6D74, 16'h0000, 16'h0000, 8'h00, CLASS_MOVE, MODE_POSTINC, 3'h2, 3'h6, 8'h04);
        chk("pop", {dec.is_stack, dec.is_store}, 16'h0002);
    endtask
    task t_imm_widths;
        run(16'h7902, 16'hBEEF, 16'h0000, 8'h00, CLASS_MOVE, MODE_IMM, 3'h4, 3'h4, 8'h04);
        chk("imm16", dec.imm, 16'hBEEF);
        chk("imm_w", dec.imm_width, FIELD_16);
        run(16'h7050, 16'h0000, 16'h8000, 8'h00, CLASS_OTHER, MODE_IMM, 3'h2, 3'h2, 8'h00);
        chk("imm3", dec.imm, 16'h0005);
        chk("imm_w", dec.imm_width, FIELD_3);
    endtask
    initial begin
        #100000;
        err_total++;
        summarize;
    end
    initial begin
        repeat (6) @(negedge mclk_in);
        chk("reset", {rdy, busy, done, fwe, fout}, 16'h0880);
        sys_rst_in = 1'b0;
        @(negedge mclk_in);
        t_byte_forms;
        t_auto_step;
        t_imm_widths;
        summarize;
    end
endmodule
bind move_instruction_decoder move_dec_monitor u_mon (.mclk_in(mclk_in), .sys_rst_in(sys_rst_in),
    .instr_valid_in(instr_valid_in), .instr_word0_in(instr_word0_in), .instr_ready_out(instr_ready_out),
    .decode_out(decode_out), .busy_out(busy_out), .done_out(done_out), .xfer_valid_in(xfer_valid_in),
    .xfer_data_in(xfer_data_in), .flags_in(flags_in), .flags_out(flags_out), .flags_we_out(flags_we_out));
